// ---- design/mcm_pkg.sv ----
// Package with register map, field layout, reset values and codes for the mode register
// Contract
// - Bit 1 of the first pulse output selection adds phase B to that output and resets to 1.
// - Bit 2 of the first pulse output selection adds phase C to that output and resets to 1.
// - All three bits of the second output selection set feed the sum of A, B and C.
// - Each bit of the second output selection includes its own phase when set, excludes when clear.
// - All three bits of the third output selection set feed the sum of A, B and C.
// - Each bit of the third output selection includes its own phase when set and resets to 1.
// - The default angle setting measures voltage to current angles per phase.
// - The second angle setting measures angles between the phase voltages.
// - A clear nominal enable computes apparent power from measured rms voltage.
// - Phase A nominal enable replaces phase A rms voltage with the nominal value.
// - Phase B nominal enable replaces phase B rms voltage with the nominal value.
// - A clear phase C nominal enable uses measured phase C rms voltage.
// - Angle field bits 10:9 code 00 V-I, 01 V-V, 10 I-I, 11 none.
// - Phase C nominal enable is bit 13, resets to 0, and replaces phase C rms voltage.
package mcm_pkg;
    localparam logic [15:0] MCM_ADDR_COMP_MODE  = 16'hE60E;
    localparam logic [15:0] MCM_ADDR_NOM_VOLT   = 16'hE610;
    localparam logic [15:0] MCM_ADDR_VOLT_ACT   = 16'hE612;
    localparam int          MCM_T1_LSB          = 0;
    localparam int          MCM_T2_LSB          = 3;
    localparam int          MCM_T3_LSB          = 6;
    localparam int          MCM_ANG_LSB         = 9;
    localparam int          MCM_VNA_BIT         = 11;
    localparam int          MCM_VNB_BIT         = 12;
    localparam int          MCM_VNC_BIT         = 13;
    localparam logic [15:0] MCM_MODE_WMASK      = 16'h3FFF;
    localparam logic [15:0] MCM_MODE_RESET      = 16'h01FF;
    localparam logic [23:0] MCM_NOM_RESET       = 24'h000000;
    localparam logic [2:0]  MCM_SEL_RESET       = 3'h7;
    localparam logic [1:0]  MCM_ANG_RESET       = 2'h0;

    typedef enum logic [1:0] {
        MCM_ANG_VI   = 2'h0,
        MCM_ANG_VV   = 2'h1,
        MCM_ANG_II   = 2'h2,
        MCM_ANG_NONE = 2'h3
    } mcm_angle_t;

    typedef enum logic [1:0] {
        MCM_BUS_IDLE = 2'h1,
        MCM_BUS_ACK  = 2'h2
    } mcm_bus_state_t;
endpackage : mcm_pkg

// ---- design/mcm_sel_if.sv ----
// Interface carrying one pulse output's phase selection and its phase terms
`timescale 1ns/100ps
interface mcm_sel_if;
    logic [2:0]  sel;
    logic [23:0] term_a;
    logic [23:0] term_b;
    logic [23:0] term_c;
    logic [25:0] sum;
    modport cfg (output sel, output term_a, output term_b, output term_c, input sum);
    modport adder (input sel, input term_a, input term_b, input term_c, output sum);
endinterface : mcm_sel_if

// ---- design/mcm_phase_sum.sv ----
// Selectable sum of three phase contributions for one pulse output
`timescale 1ns/100ps
module mcm_phase_sum (
    mcm_sel_if.adder p
);
    logic [25:0] sum_next;

    // Gate each phase by its select bit, then add
    always_comb begin
        sum_next = 26'h0000000;
        if (p.sel[0]) begin
            sum_next = sum_next + {2'h0, p.term_a};
        end
        if (p.sel[1]) begin
            sum_next = sum_next + {2'h0, p.term_b};
        end
        if (p.sel[2]) begin
            sum_next = sum_next + {2'h0, p.term_c};
        end
    end
    assign p.sum = sum_next;
endmodule : mcm_phase_sum

// ---- design/mcm_mode_cfg.sv ----
// Computation mode register with Wishbone slave and mode-steered datapath
`timescale 1ns/100ps
module mcm_mode_cfg (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        comp_strobe_i,
    input  wire logic [23:0] pwr_a_i,
    input  wire logic [23:0] pwr_b_i,
    input  wire logic [23:0] pwr_c_i,
    input  wire logic [23:0] vrms_a_i,
    input  wire logic [23:0] vrms_b_i,
    input  wire logic [23:0] vrms_c_i,
    output logic      [25:0] pulse_output_one_o,
    output logic      [25:0] pulse_output_two_o,
    output logic      [25:0] pulse_output_three_o,
    output logic      [23:0] vrms_used_a_o,
    output logic      [23:0] vrms_used_b_o,
    output logic      [23:0] vrms_used_c_o,
    output logic      [1:0]  angle_measure_select_o,
    output logic             angle_volt_volt_o,
    output logic             angle_curr_curr_o,
    output logic             angle_enable_o
);
    logic [15:0] mode_reg;
    logic [15:0] mode_next;
    logic [23:0] nom_reg;
    logic [23:0] nom_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic        ack_reg;
    logic        ack_next;
    mcm_pkg::mcm_bus_state_t bus_reg;
    mcm_pkg::mcm_bus_state_t bus_next;
    logic [15:0] wmask;
    logic [15:0] rd_mode;

    // Bus state machine: answer one cycle after request, drop ack next
    always_comb begin
        bus_next  = bus_reg;
        ack_next  = 1'b0;
        mode_next = mode_reg;
        nom_next  = nom_reg;
        rdat_next = rdat_reg;
        wmask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & mcm_pkg::MCM_MODE_WMASK;
        rd_mode   = mode_reg & mcm_pkg::MCM_MODE_WMASK;
        unique case (bus_reg)
            mcm_pkg::MCM_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_next  = mcm_pkg::MCM_BUS_ACK;
                    ack_next  = 1'b1;
                    rdat_next = 32'h00000000;
                    unique case (wb_adr_i)
                        mcm_pkg::MCM_ADDR_COMP_MODE: begin
                            // Write lands now, used by next strobe
                            if (wb_we_i) begin
                                mode_next = (mode_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                            end
                            rdat_next = {16'h0000, rd_mode};
                        end
                        mcm_pkg::MCM_ADDR_NOM_VOLT: begin
                            if (wb_we_i) begin
                                if (wb_sel_i[0]) nom_next[7:0] = wb_dat_i[7:0];
                                if (wb_sel_i[1]) nom_next[15:8] = wb_dat_i[15:8];
                                if (wb_sel_i[2]) nom_next[23:16] = wb_dat_i[23:16];
                            end
                            rdat_next = {8'h00, nom_reg};
                        end
                        mcm_pkg::MCM_ADDR_VOLT_ACT: begin
                            rdat_next = {8'h00, vrms_used_a_o};
                        end
                        default: begin
                            // Unmapped: acked, writes dropped, reads zero
                            rdat_next = 32'h00000000;
                        end
                    endcase
                end
            end
            mcm_pkg::MCM_BUS_ACK: begin
                // One idle cycle so a held strobe is not served twice
                bus_next = mcm_pkg::MCM_BUS_IDLE;
            end
            default: begin
                bus_next = mcm_pkg::MCM_BUS_IDLE;
            end
        endcase
    end

    // Register the bus and configuration state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_reg  <= mcm_pkg::MCM_BUS_IDLE;
            ack_reg  <= 1'b0;
            mode_reg <= mcm_pkg::MCM_MODE_RESET;
            nom_reg  <= mcm_pkg::MCM_NOM_RESET;
            rdat_reg <= 32'h00000000;
        end else begin
            bus_reg  <= bus_next;
            ack_reg  <= ack_next;
            mode_reg <= mode_next;
            nom_reg  <= nom_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // Field views of the mode register
    logic [2:0] t1_sel;
    logic [2:0] t2_sel;
    logic [2:0] t3_sel;
    logic [1:0] ang_sel;
    logic       vn_a;
    logic       vn_b;
    logic       vn_c;
    assign t1_sel  = mode_reg[mcm_pkg::MCM_T1_LSB +: 3];
    assign t2_sel  = mode_reg[mcm_pkg::MCM_T2_LSB +: 3];
    assign t3_sel  = mode_reg[mcm_pkg::MCM_T3_LSB +: 3];
    assign ang_sel = mode_reg[mcm_pkg::MCM_ANG_LSB +: 2];
    assign vn_a    = mode_reg[mcm_pkg::MCM_VNA_BIT];
    assign vn_b    = mode_reg[mcm_pkg::MCM_VNB_BIT];
    assign vn_c    = mode_reg[mcm_pkg::MCM_VNC_BIT];

    // Three selectable phase adders, one per pulse output
    mcm_sel_if s1 ();
    mcm_sel_if s2 ();
    mcm_sel_if s3 ();
    assign s1.sel = t1_sel;
    assign s2.sel = t2_sel;
    assign s3.sel = t3_sel;
    assign s1.term_a = pwr_a_i;
    assign s1.term_b = pwr_b_i;
    assign s1.term_c = pwr_c_i;
    assign s2.term_a = pwr_a_i;
    assign s2.term_b = pwr_b_i;
    assign s2.term_c = pwr_c_i;
    assign s3.term_a = pwr_a_i;
    assign s3.term_b = pwr_b_i;
    assign s3.term_c = pwr_c_i;
    mcm_phase_sum u_sum1 (.p(s1));
    mcm_phase_sum u_sum2 (.p(s2));
    mcm_phase_sum u_sum3 (.p(s3));

    // Computation results, updated once per computation strobe
    logic [25:0] cf1_reg;
    logic [25:0] cf1_next;
    logic [25:0] cf2_reg;
    logic [25:0] cf2_next;
    logic [25:0] cf3_reg;
    logic [25:0] cf3_next;
    logic [23:0] va_reg;
    logic [23:0] va_next;
    logic [23:0] vb_reg;
    logic [23:0] vb_next;
    logic [23:0] vc_reg;
    logic [23:0] vc_next;
    logic [1:0]  ang_reg;
    logic [1:0]  ang_next;
    logic        avv_reg;
    logic        avv_next;
    logic        aii_reg;
    logic        aii_next;
    logic        aen_reg;
    logic        aen_next;

    // Nominal voltage swaps in for measured rms; inputs assumed in clk domain
    always_comb begin
        cf1_next = cf1_reg;
        cf2_next = cf2_reg;
        cf3_next = cf3_reg;
        va_next  = va_reg;
        vb_next  = vb_reg;
        vc_next  = vc_reg;
        ang_next = ang_reg;
        avv_next = avv_reg;
        aii_next = aii_reg;
        aen_next = aen_reg;
        if (comp_strobe_i) begin
            cf1_next = s1.sum;
            cf2_next = s2.sum;
            cf3_next = s3.sum;
            va_next  = vn_a ? nom_reg : vrms_a_i;
            vb_next  = vn_b ? nom_reg : vrms_b_i;
            vc_next  = vn_c ? nom_reg : vrms_c_i;
            ang_next = ang_sel;
            avv_next = (ang_sel == mcm_pkg::MCM_ANG_VV);
            aii_next = (ang_sel == mcm_pkg::MCM_ANG_II);
            aen_next = (ang_sel != mcm_pkg::MCM_ANG_NONE);
        end
    end

    // Register the computation results
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cf1_reg <= 26'h0000000;
            cf2_reg <= 26'h0000000;
            cf3_reg <= 26'h0000000;
            va_reg  <= 24'h000000;
            vb_reg  <= 24'h000000;
            vc_reg  <= 24'h000000;
            ang_reg <= mcm_pkg::MCM_ANG_RESET;
            avv_reg <= 1'b0;
            aii_reg <= 1'b0;
            aen_reg <= 1'b1;
        end else begin
            cf1_reg <= cf1_next;
            cf2_reg <= cf2_next;
            cf3_reg <= cf3_next;
            va_reg  <= va_next;
            vb_reg  <= vb_next;
            vc_reg  <= vc_next;
            ang_reg <= ang_next;
            avv_reg <= avv_next;
            aii_reg <= aii_next;
            aen_reg <= aen_next;
        end
    end

    assign pulse_output_one_o     = cf1_reg;
    assign pulse_output_two_o     = cf2_reg;
    assign pulse_output_three_o   = cf3_reg;
    assign vrms_used_a_o          = va_reg;
    assign vrms_used_b_o          = vb_reg;
    assign vrms_used_c_o          = vc_reg;
    assign angle_measure_select_o = ang_reg;
    assign angle_volt_volt_o      = avv_reg;
    assign angle_curr_curr_o      = aii_reg;
    assign angle_enable_o         = aen_reg;

    // Checks next to the logic: values seen at the first edge after reset
    sel_reset_a: assert property (@(posedge clk_i) $past(rst_i) && !rst_i |->
        mode_reg[8:0] == 9'h1FF && !mode_reg[13]) else $error("mode reset wrong");
    out_reset_a: assert property (@(posedge clk_i) $past(rst_i) && !rst_i |->
        angle_enable_o && !wb_ack_o && vrms_used_a_o == 24'h000000)
        else $error("output reset wrong");

    // Pulse output sums follow the selection seen at the strobe
    cf1_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && t1_sel == 3'h6 |=>
        cf1_reg == {2'h0, $past(pwr_b_i)} + {2'h0, $past(pwr_c_i)})
        else $error("output one sum wrong");
    cf2_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && t2_sel == 3'h7 |=>
        cf2_reg == {2'h0, $past(pwr_a_i)} + {2'h0, $past(pwr_b_i)} + {2'h0, $past(pwr_c_i)})
        else $error("output two sum wrong");
    cf2_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && t2_sel == 3'h2 |=> cf2_reg == {2'h0, $past(pwr_b_i)})
        else $error("output two single phase wrong");
    cf3_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && t3_sel == 3'h7 |=>
        cf3_reg == {2'h0, $past(pwr_a_i)} + {2'h0, $past(pwr_b_i)} + {2'h0, $past(pwr_c_i)})
        else $error("output three sum wrong");
    cf3_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && t3_sel == 3'h4 |=> cf3_reg == {2'h0, $past(pwr_c_i)})
        else $error("output three single phase wrong");

    // Angle decode taken at the strobe
    angle_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i |=> angle_enable_o == ($past(ang_sel) != 2'h3) &&
        angle_volt_volt_o == ($past(ang_sel) == 2'h1) &&
        angle_curr_curr_o == ($past(ang_sel) == 2'h2)) else $error("angle decode wrong");

    // Nominal or measured rms voltage, phase by phase
    nom_a_sub_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && vn_a |=> vrms_used_a_o == $past(nom_reg))
        else $error("phase a nominal not used");
    meas_a_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && !vn_a |=> vrms_used_a_o == $past(vrms_a_i))
        else $error("phase a measured not used");
    nom_b_sub_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && vn_b |=> vrms_used_b_o == $past(nom_reg))
        else $error("phase b nominal not used");
    meas_c_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && !vn_c |=> vrms_used_c_o == $past(vrms_c_i))
        else $error("phase c measured not used");
    nom_c_sub_a: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_strobe_i && vn_c |=> vrms_used_c_o == $past(nom_reg))
        else $error("phase c nominal not used");

    // Write lands at the taking edge; results move only on a strobe
    write_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_reg == mcm_pkg::MCM_BUS_IDLE && wb_cyc_i && wb_stb_i && wb_we_i &&
        wb_adr_i == mcm_pkg::MCM_ADDR_COMP_MODE && wb_sel_i[1:0] == 2'h3 |=>
        mode_reg[13:0] == $past(wb_dat_i[13:0]) && wb_ack_o ##1 !wb_ack_o)
        else $error("mode write not applied");
    result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !comp_strobe_i |=> $stable(cf1_reg) && $stable(va_reg) && $stable(ang_reg))
        else $error("output moved without strobe");

    // Scenarios worth seeing in a run
    wr_mode_c: cover property (@(posedge clk_i) wb_ack_o && wb_we_i &&
        wb_adr_i == mcm_pkg::MCM_ADDR_COMP_MODE);
    nom_used_c: cover property (@(posedge clk_i) comp_strobe_i && vn_c);
    ang_off_c: cover property (@(posedge clk_i) comp_strobe_i && ang_sel == 2'h3);
    ang_vv_c: cover property (@(posedge clk_i) comp_strobe_i && ang_sel == 2'h1);
    pair_bc_c: cover property (@(posedge clk_i) comp_strobe_i && t1_sel == 3'h6);
endmodule : mcm_mode_cfg

// ---- dv/testbench.sv ----
// Self-checking bench for the computation mode register block
`timescale 1ns/100ps
module testbench;
    localparam int TIMEOUT = 8000;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [15:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        comp_strobe_i;
    logic [23:0] pwr_a_i, pwr_b_i, pwr_c_i;
    logic [23:0] vrms_a_i, vrms_b_i, vrms_c_i;
    logic [25:0] p1_o, p2_o, p3_o;
    logic [23:0] vu_a_o, vu_b_o, vu_c_o;
    logic [1:0]  ang_o;
    logic        vv_o, cc_o, aen_o;
    int          num_errors, comparisons, cycles;
    // Mirrors: what was written, and what was latched at the last strobe
    logic [15:0] mode_m, mode_s;
    logic [23:0] nom_m, nom_s, pa, pb, pc, va, vb, vc;
    logic [31:0] rd, wv;
    logic [3:0]  sel_v;

    mcm_mode_cfg u_mcm_mode_cfg (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .comp_strobe_i(comp_strobe_i), .pwr_a_i(pwr_a_i), .pwr_b_i(pwr_b_i),
        .pwr_c_i(pwr_c_i), .vrms_a_i(vrms_a_i), .vrms_b_i(vrms_b_i), .vrms_c_i(vrms_c_i),
        .pulse_output_one_o(p1_o), .pulse_output_two_o(p2_o), .pulse_output_three_o(p3_o),
        .vrms_used_a_o(vu_a_o), .vrms_used_b_o(vu_b_o), .vrms_used_c_o(vu_c_o),
        .angle_measure_select_o(ang_o), .angle_volt_volt_o(vv_o),
        .angle_curr_curr_o(cc_o), .angle_enable_o(aen_o));

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Hang guard: a stuck handshake still ends in the verdict
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bus

    task automatic chk_dp(input logic [25:0] got, input logic [25:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_dp

    // Selected sum of the three phase contributions
    function automatic logic [25:0] exp_sum(input logic [2:0] s);
        exp_sum = (s[0] ? {2'h0, pa} : 26'h0) + (s[1] ? {2'h0, pb} : 26'h0)
                + (s[2] ? {2'h0, pc} : 26'h0);
    endfunction : exp_sum

    function automatic logic [25:0] exp_v(input logic en, input logic [23:0] meas);
        exp_v = {2'h0, en ? nom_s : meas};
    endfunction : exp_v

    // Classic single cycle; holds everything until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [31:0] wd,
                           output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= sel_v;
        // No own limit: only the bench timeout ends a stuck wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_xfer

    // Outputs against the values latched at the last computation strobe
    task automatic check_outputs();
        chk_dp(p1_o, exp_sum(mode_s[2:0]));
        chk_dp(p2_o, exp_sum(mode_s[5:3]));
        chk_dp(p3_o, exp_sum(mode_s[8:6]));
        chk_dp({2'h0, vu_a_o}, exp_v(mode_s[11], va));
        chk_dp({2'h0, vu_b_o}, exp_v(mode_s[12], vb));
        chk_dp({2'h0, vu_c_o}, exp_v(mode_s[13], vc));
        chk_dp({24'h0, ang_o}, {24'h0, mode_s[10:9]});
        chk_dp({25'h0, vv_o}, {25'h0, mode_s[10:9] == 2'h1});
        chk_dp({25'h0, cc_o}, {25'h0, mode_s[10:9] == 2'h2});
        chk_dp({25'h0, aen_o}, {25'h0, mode_s[10:9] != 2'h3});
    endtask : check_outputs

    // One computation strobe with fresh random phase data
    task automatic pulse_comp();
        @(posedge clk_i);
        pa = 24'($urandom);
        pb = 24'($urandom);
        pc = 24'($urandom);
        va = 24'($urandom);
        vb = 24'($urandom);
        vc = 24'($urandom);
        comp_strobe_i <= 1'b1;
        {pwr_a_i, pwr_b_i, pwr_c_i} <= {pa, pb, pc};
        {vrms_a_i, vrms_b_i, vrms_c_i} <= {va, vb, vc};
        mode_s = mode_m;
        nom_s  = nom_m;
        @(posedge clk_i);
        comp_strobe_i <= 1'b0;
        // Phase A inputs move on at once, so outputs must hold the latched values
        pwr_a_i  <= ~pa;
        vrms_a_i <= ~va;
        #1;
        check_outputs();
    endtask : pulse_comp

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, comp_strobe_i} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 52'h0;
        {pwr_a_i, pwr_b_i, pwr_c_i, vrms_a_i, vrms_b_i, vrms_c_i} = 144'h0;
        {pa, pb, pc, va, vb, vc} = 144'h0;
        num_errors = 0;
        comparisons = 0;
        sel_v = 4'hF;
        mode_m = 16'h01FF;
        nom_m = 24'h000000;
        mode_s = mode_m;
        nom_s = nom_m;
        void'($urandom(14));
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check_outputs();
        wb_xfer(1'b0, 16'hE60E, 32'h0, rd);
        chk_bus(rd, 32'h000001FF);
        wb_xfer(1'b0, 16'hE610, 32'h0, rd);
        chk_bus(rd, 32'h0);
        pulse_comp();
        // Corner values first, then random modes; every angle code recurs
        for (int i = 0; i < 40; i++) begin
            // Third pass: B+C on one, B alone on two, C alone on three, C nominal
            wv = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF :
                 (i == 2) ? 32'h00002116 : $urandom;
            wv[10:9] = 2'(i);
            wb_xfer(1'b1, 16'hE60E, wv, rd);
            mode_m = wv[15:0] & 16'h3FFF;
            if (i % 3 == 0) begin
                nom_m = 24'($urandom);
                wb_xfer(1'b1, 16'hE610, {8'hA5, nom_m}, rd);
                wb_xfer(1'b0, 16'hE610, 32'h0, rd);
                chk_bus(rd, {8'h0, nom_m});
            end
            wb_xfer(1'b0, 16'hE60E, 32'h0, rd);
            chk_bus(rd, {16'h0, mode_m});
            #1;
            check_outputs();
            pulse_comp();
            wb_xfer(1'b0, 16'hE612, 32'h0, rd);
            chk_bus(rd, 32'(exp_v(mode_s[11], va)));
        end
        // High byte lane alone: low byte of the mode must survive
        sel_v = 4'h2;
        wv = $urandom;
        wb_xfer(1'b1, 16'hE60E, wv, rd);
        sel_v = 4'hF;
        mode_m = (mode_m & 16'h00FF) | (wv[15:0] & 16'h3F00);
        wb_xfer(1'b0, 16'hE60E, 32'h0, rd);
        chk_bus(rd, {16'h0, mode_m});
        // Unmapped place: write ignored, reads zero, mode untouched
        wb_xfer(1'b1, 16'hE700, $urandom, rd);
        wb_xfer(1'b0, 16'hE700, 32'h0, rd);
        chk_bus(rd, 32'h0);
        wb_xfer(1'b0, 16'hE60E, 32'h0, rd);
        chk_bus(rd, {16'h0, mode_m});
        finish_test();
    end
endmodule : testbench
